// File: pfbr_regs.svh
// Timing figures, fault codes and frame layout for the power fault blink reporter.
// Assumes a 40 MHz sys_clk; only the millisecond cycle count below is derived from that rate.
//
// Functional notes
// - Fault shows as flashing white indicator
// - Frame opens with two seconds dark
// - Eight code bits follow, LSB first
// - One bit: lit for one second
// - Zero bit: lit for half second
// - Half second dark between code bits
// - E rail late after enable: 0x20
// - E rail drops while on: 0x21
// - E rail drops in wake-capable off: 0x22
// - E rail rises in soft-off: 0x23
// - B rail late after enable: 0x30
// - B rail drops while on: 0x31
// - B rail drops in low-power off: 0x32
// - B rail rises in soft-off: 0x33
// - P rail late after enable: 0x40
// - P rail drops while on: 0x41
// - P rail rises in soft-off: 0x43
`ifndef PFBR_REGS_SVH
`define PFBR_REGS_SVH

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define PFBR_CLK_HZ 40000000
`define PFBR_TICK_TIME_NS 1000000
`define PFBR_MS_CYCLES ((`PFBR_TICK_TIME_NS / 1000) * (`PFBR_CLK_HZ / 1000000))

// ----------------------------------------------------------------
// Durations in their own units
// ----------------------------------------------------------------
`define PFBR_RAIL_TIMEOUT_S 1
`define PFBR_START_S 2
`define PFBR_ONE_S 1
`define PFBR_ZERO_MS 500
`define PFBR_GAP_MS 500
`define PFBR_UNIT_MS 500

`define PFBR_RAIL_TIMEOUT_MS (`PFBR_RAIL_TIMEOUT_S * 1000)
`define PFBR_START_MS (`PFBR_START_S * 1000)
`define PFBR_ONE_MS (`PFBR_ONE_S * 1000)

// Durations in half-second units
`define PFBR_START_UNITS (3'(`PFBR_START_MS / `PFBR_UNIT_MS))
`define PFBR_ONE_UNITS (3'(`PFBR_ONE_MS / `PFBR_UNIT_MS))
`define PFBR_ZERO_UNITS (3'(`PFBR_ZERO_MS / `PFBR_UNIT_MS))
`define PFBR_GAP_UNITS (3'(`PFBR_GAP_MS / `PFBR_UNIT_MS))

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define PFBR_LAST_BIT 3'h7

// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define PFBR_CODE_E_TIMEOUT 8'h20
`define PFBR_CODE_E_DROP_ON 8'h21
`define PFBR_CODE_E_DROP_OFF 8'h22
`define PFBR_CODE_E_RISE_S5 8'h23
`define PFBR_CODE_B_TIMEOUT 8'h30
`define PFBR_CODE_B_DROP_ON 8'h31
`define PFBR_CODE_B_DROP_OFF 8'h32
`define PFBR_CODE_B_RISE_S5 8'h33
`define PFBR_CODE_P_TIMEOUT 8'h40
`define PFBR_CODE_P_DROP_ON 8'h41
`define PFBR_CODE_P_RISE_S5 8'h43
`define PFBR_CODE_NONE 8'h00

// Rail positions in the synchroniser vector
`define PFBR_PIN_E 0
`define PFBR_PIN_B 1
`define PFBR_PIN_P 2
`define PFBR_PIN_EN 3

`endif

// File: pfbr_pkg.sv
// Types shared by the power fault blink reporter modules.
// Assumes nothing of its surroundings.
package pfbr_pkg;

  typedef logic [7:0] pfbr_code_type;

  typedef enum logic [1:0] {
    BL_IDLE,
    BL_START,
    BL_BIT,
    BL_GAP
  } pfbr_blink_type;

endpackage

// File: pfbr_tick.sv
// Free-running divider that emits a one-cycle pulse every LIMIT advances.
// Assumes advance and restart come from logic on sys_clk.
`timescale 1ns/1ps
`include "pfbr_regs.svh"

module pfbr_tick #(
  parameter int WIDTH = 16,
  parameter int LIMIT = 40000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic advance,
  output logic pulse
);
  import pfbr_pkg::*;

  logic [WIDTH-1:0] count;
  wire atLimit = (count == WIDTH'(LIMIT - 1));

  always_ff @(posedge sys_clk) begin
    if (!reset_n || restart) begin
      count <= '0;
    end else if (advance) begin
      count <= atLimit ? '0 : count + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= advance && atLimit && !restart;
    end
  end

  a_tick_single: assert property (@(posedge sys_clk) disable iff (!reset_n) pulse |=> !pulse)
    else $error("tick pulse lasted more than one cycle");

endmodule

// File: pfbr_reporter.sv
// Power fault monitor for three supply rails and the blink reporter on the
// white DC in / battery indicator.
// Assumes rail good pins and the rail enable request are asynchronous pins;
// power state flags and faultClear come from logic on sys_clk.
`timescale 1ns/1ps
`include "pfbr_regs.svh"

module pfbr_reporter #(
  parameter int MS_CYCLES = `PFBR_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic eRailGood,
  input wire logic bRailGood,
  input wire logic pRailOk,
  input wire logic railEnableRequest,
  input wire logic powerOnState,
  input wire logic lowPowerOffState,
  input wire logic deeperLowPowerOffState,
  input wire logic softOffState,
  input wire logic faultClear,
  output logic indicatorWhite,
  output logic faultLatched,
  output pfbr_pkg::pfbr_code_type faultCode
);
  import pfbr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] pinLast;
  logic [2:0] syncFill;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      pinLast <= 4'h0;
      syncFill <= 3'h0;
    end else begin
      pinMeta <= {railEnableRequest, pRailOk, bRailGood, eRailGood};
      pinSync <= pinMeta;
      pinLast <= pinSync;
      syncFill <= {syncFill[1:0], 1'b1};
    end
  end

  // Edges stay quiet until pinLast holds a real sample, so a rail that is
  // already up at reset release is not taken for a rise
  wire edgesArmed = syncFill[2];

  wire eGood = pinSync[`PFBR_PIN_E];
  wire bGood = pinSync[`PFBR_PIN_B];
  wire pGood = pinSync[`PFBR_PIN_P];
  wire enReq = pinSync[`PFBR_PIN_EN];

  wire eFell = edgesArmed && pinLast[`PFBR_PIN_E] && !eGood;
  wire bFell = edgesArmed && pinLast[`PFBR_PIN_B] && !bGood;
  wire pFell = edgesArmed && pinLast[`PFBR_PIN_P] && !pGood;
  wire eRose = edgesArmed && !pinLast[`PFBR_PIN_E] && eGood;
  wire bRose = edgesArmed && !pinLast[`PFBR_PIN_B] && bGood;
  wire pRose = edgesArmed && !pinLast[`PFBR_PIN_P] && pGood;

  // ----------------------------------------------------------------
  // Timebase: millisecond tick and half-second unit tick
  // ----------------------------------------------------------------
  logic msTick;
  logic halfTick;
  logic stateMove;

  pfbr_tick #(
    .WIDTH(16),
    .LIMIT(MS_CYCLES)
  ) u_ms_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(1'b0),
    .advance(1'b1),
    .pulse(msTick)
  );

  // Restarted on every state change so each period starts a full unit
  pfbr_tick #(
    .WIDTH(10),
    .LIMIT(`PFBR_UNIT_MS)
  ) u_half_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(stateMove),
    .advance(msTick),
    .pulse(halfTick)
  );

  // ----------------------------------------------------------------
  // Power-on timeout
  // ----------------------------------------------------------------
  logic [10:0] railWaitMs;
  wire powerOnProcess = enReq && !powerOnState;
  // One extra tick so the limit is passed, not merely met
  wire [10:0] railWaitLimit = 11'(`PFBR_RAIL_TIMEOUT_MS + 1);
  wire railTimedOut = powerOnProcess && (railWaitMs == railWaitLimit);

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !powerOnProcess) begin
      railWaitMs <= 11'h000;
    end else if (msTick && !railTimedOut) begin
      railWaitMs <= railWaitMs + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection, E rail first, then B, then P
  // ----------------------------------------------------------------
  wire wakeOff = lowPowerOffState || deeperLowPowerOffState;
  wire eTimeout = railTimedOut && !eGood;
  wire eDropOn = powerOnState && eFell;
  wire eDropOff = wakeOff && eFell;
  wire eRiseS5 = softOffState && eRose;
  wire bTimeout = railTimedOut && !bGood;
  wire bDropOn = powerOnState && bFell;
  wire bDropOff = lowPowerOffState && bFell;
  wire bRiseS5 = softOffState && bRose;
  wire pTimeout = railTimedOut && !pGood;
  wire pDropOn = powerOnState && pFell;
  wire pRiseS5 = softOffState && pRose;

  wire faultSeen = eTimeout || eDropOn || eDropOff || eRiseS5 ||
                   bTimeout || bDropOn || bDropOff || bRiseS5 ||
                   pTimeout || pDropOn || pRiseS5;

  wire pfbr_code_type seenCode =
    eTimeout ? `PFBR_CODE_E_TIMEOUT :
    eDropOn  ? `PFBR_CODE_E_DROP_ON :
    eDropOff ? `PFBR_CODE_E_DROP_OFF :
    eRiseS5  ? `PFBR_CODE_E_RISE_S5 :
    bTimeout ? `PFBR_CODE_B_TIMEOUT :
    bDropOn  ? `PFBR_CODE_B_DROP_ON :
    bDropOff ? `PFBR_CODE_B_DROP_OFF :
    bRiseS5  ? `PFBR_CODE_B_RISE_S5 :
    pTimeout ? `PFBR_CODE_P_TIMEOUT :
    pDropOn  ? `PFBR_CODE_P_DROP_ON :
    pRiseS5  ? `PFBR_CODE_P_RISE_S5 :
               `PFBR_CODE_NONE;

  // First fault is kept; a new fault in the clear cycle wins over the clear
  wire takeFault = faultSeen && (!faultLatched || faultClear);
  // Clear that empties the latch; the indicator goes dark on the same edge
  wire dropFault = faultClear && !takeFault;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      faultLatched <= 1'b0;
      faultCode <= `PFBR_CODE_NONE;
    end else if (takeFault) begin
      faultLatched <= 1'b1;
      faultCode <= seenCode;
    end else if (faultClear) begin
      faultLatched <= 1'b0;
      faultCode <= `PFBR_CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Blink frame sequencer
  // ----------------------------------------------------------------
  pfbr_blink_type state;
  pfbr_blink_type next_state;
  logic [2:0] unitCount;
  logic [2:0] bitIdx;

  wire currentBit = faultCode[bitIdx];
  wire [2:0] bitUnits = currentBit ? `PFBR_ONE_UNITS : `PFBR_ZERO_UNITS;
  wire [2:0] unitTarget = (state == BL_START) ? `PFBR_START_UNITS :
                          (state == BL_GAP) ? `PFBR_GAP_UNITS : bitUnits;
  wire unitDone = halfTick && (unitCount == unitTarget - 3'h1);
  wire lastBit = (bitIdx == `PFBR_LAST_BIT);

  always_comb begin
    next_state = state;
    case (state)
      BL_IDLE: begin
        if (faultLatched) begin
          next_state = BL_START;
        end
      end
      BL_START: begin
        if (unitDone) begin
          next_state = BL_BIT;
        end
      end
      BL_BIT: begin
        if (unitDone) begin
          next_state = lastBit ? BL_START : BL_GAP;
        end
      end
      BL_GAP: begin
        if (unitDone) begin
          next_state = BL_BIT;
        end
      end
      default: begin
        next_state = BL_IDLE;
      end
    endcase
    if (!faultLatched || dropFault) begin
      next_state = BL_IDLE;
    end
  end

  assign stateMove = (next_state != state);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= BL_IDLE;
      unitCount <= 3'h0;
    end else begin
      state <= next_state;
      unitCount <= stateMove ? 3'h0 : unitCount + {2'h0, halfTick};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || next_state == BL_START) begin
      bitIdx <= 3'h0;
    end else if (state == BL_GAP && next_state == BL_BIT) begin
      bitIdx <= bitIdx + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      indicatorWhite <= 1'b0;
    end else begin
      indicatorWhite <= (next_state == BL_BIT);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Millisecond counts of the current lit and dark stretches
  logic [11:0] litMs;
  logic [11:0] darkMs;
  logic shownBit;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      litMs <= 12'h000;
      darkMs <= 12'h000;
      shownBit <= 1'b0;
    end else begin
      litMs <= indicatorWhite ? litMs + {11'h000, msTick} : 12'h000;
      darkMs <= indicatorWhite ? 12'h000 : darkMs + {11'h000, msTick};
      if (state == BL_BIT) begin
        shownBit <= currentBit;
      end
    end
  end

  sequence s_lit_end;
    $fell(indicatorWhite) && faultLatched;
  endsequence

  sequence s_timeout_hit;
    !faultLatched && railTimedOut;
  endsequence

  a_white_needs_fault: assert property (indicatorWhite |-> faultLatched)
    else $error("indicator lit without a latched fault");

  a_start_dark: assert property (state == BL_START |-> !indicatorWhite)
    else $error("indicator lit during the start period");

  a_first_bit_lsb: assert property ($rose(state == BL_BIT) && $past(state) == BL_START |-> bitIdx == 3'h0)
    else $error("frame did not open with the least significant bit");

  a_one_length: assert property (s_lit_end and shownBit |->
      litMs >= 12'(`PFBR_ONE_MS - 1) && litMs <= 12'(`PFBR_ONE_MS + 1))
    else $error("one bit not lit for one second");

  a_zero_length: assert property (s_lit_end and !shownBit |->
      litMs >= 12'(`PFBR_ZERO_MS - 1) && litMs <= 12'(`PFBR_ZERO_MS + 1))
    else $error("zero bit not lit for half a second");

  a_gap_length: assert property ($rose(indicatorWhite) && $past(state) == BL_GAP |->
      darkMs >= 12'(`PFBR_GAP_MS - 1) && darkMs <= 12'(`PFBR_GAP_MS + 1))
    else $error("gap between bits not half a second");

  a_e_timeout: assert property (s_timeout_hit and !eGood |=> faultCode == `PFBR_CODE_E_TIMEOUT)
    else $error("late E rail not reported as 0x20");

  a_e_drop_on: assert property (!faultLatched && powerOnState && eFell |=>
      faultLatched && faultCode == `PFBR_CODE_E_DROP_ON)
    else $error("E rail drop while on not reported as 0x21");

  a_b_rise_s5: assert property (!faultLatched && softOffState && bRose && !eRose |=>
      faultCode == `PFBR_CODE_B_RISE_S5)
    else $error("B rail rise in soft-off not reported as 0x33");

  // Quiet E and B rails, so a lower priority fault is the one taken
  wire eQuiet = !eFell && !eRose;
  wire bQuiet = !bFell && !bRose;

  a_e_drop_off: assert property (!faultLatched && !railTimedOut && !powerOnState && wakeOff && eFell |=>
      faultCode == `PFBR_CODE_E_DROP_OFF)
    else $error("E rail drop in wake-capable off not reported as 0x22");

  a_e_rise_s5: assert property (!faultLatched && softOffState && eRose |=>
      faultCode == `PFBR_CODE_E_RISE_S5)
    else $error("E rail rise in soft-off not reported as 0x23");

  a_b_timeout: assert property (!faultLatched && railTimedOut && eGood && eQuiet && !bGood |=>
      faultCode == `PFBR_CODE_B_TIMEOUT)
    else $error("late B rail not reported as 0x30");

  a_b_drop_on: assert property (!faultLatched && powerOnState && eQuiet && bFell |=>
      faultCode == `PFBR_CODE_B_DROP_ON)
    else $error("B rail drop while on not reported as 0x31");

  a_b_drop_off: assert property (!faultLatched && !railTimedOut && !powerOnState && lowPowerOffState &&
      eQuiet && bFell |=> faultCode == `PFBR_CODE_B_DROP_OFF)
    else $error("B rail drop in low-power off not reported as 0x32");

  a_p_timeout: assert property (!faultLatched && railTimedOut && eGood && bGood && eQuiet && bQuiet &&
      !pGood |=> faultCode == `PFBR_CODE_P_TIMEOUT)
    else $error("late P rail not reported as 0x40");

  a_p_drop_on: assert property (!faultLatched && powerOnState && eQuiet && bQuiet && pFell |=>
      faultCode == `PFBR_CODE_P_DROP_ON)
    else $error("P rail drop while on not reported as 0x41");

  a_p_rise_s5: assert property (!faultLatched && !railTimedOut && softOffState && eQuiet && bQuiet &&
      pRose |=> faultCode == `PFBR_CODE_P_RISE_S5)
    else $error("P rail rise in soft-off not reported as 0x43");

  a_frame_repeats: assert property (state == BL_BIT && lastBit && unitDone && faultLatched && !faultClear |=>
      state == BL_START ##1 !indicatorWhite)
    else $error("frame did not restart with a start period");

  a_clear_idles: assert property (faultClear && !faultSeen |=> !faultLatched ##1 !indicatorWhite)
    else $error("indicator kept blinking after the fault was cleared");

endmodule

// File: pfbr_rail_model.sv
// Behavioural supply rails seen by the power fault blink reporter.
// Assumes the bench changes railMode just after a rising edge of sys_clk.
`timescale 1ns/1ps

module pfbr_rail_model #(
  parameter int RAMP = 8
) (
  input wire logic sys_clk,
  input wire logic railEnableRequest,
  input wire logic [5:0] railMode,
  output wire logic [2:0] railPin
);
  logic [RAMP-1:0] ramp = '0;

  // ----------------------------------------------------------------
  // Ramp and per-rail override
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    ramp <= {ramp[RAMP-2:0], railEnableRequest};
  end

  // Mode per rail: 0 follows the enable ramp, 1 stuck low, 2 stuck high
  for (genvar i = 0; i < 3; i++) begin : g_rail
    assign railPin[i] = (railMode[2*i+:2] == 2'h0) ? ramp[RAMP-1] : (railMode[2*i+:2] == 2'h2);
  end
endmodule

// File: tb.sv
// Self-checking bench for the power fault blink reporter.
// Assumes the reporter runs with a shortened millisecond tick of MS cycles.
`timescale 1ns/1ps

module tb;
  import pfbr_pkg::*;
  localparam int MS = 2;
  localparam int U = 500 * MS;
  localparam int TOL = 8 * MS;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic railEnableRequest = 1'b0;
  logic powerOnState = 1'b0;
  logic lowPowerOffState = 1'b0;
  logic deeperLowPowerOffState = 1'b0;
  logic softOffState = 1'b0;
  logic faultClear = 1'b0;
  logic [5:0] railMode = 6'h00;
  logic [2:0] railPin;
  logic indicatorWhite;
  logic faultLatched;
  pfbr_code_type faultCode;
  int error_cnt = 0;
  int compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  pfbr_rail_model u_rails (.sys_clk(sys_clk), .railEnableRequest(railEnableRequest), .railMode(railMode),
    .railPin(railPin));

  pfbr_reporter #(.MS_CYCLES(MS)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .eRailGood(railPin[0]),
    .bRailGood(railPin[1]), .pRailOk(railPin[2]), .railEnableRequest(railEnableRequest),
    .powerOnState(powerOnState), .lowPowerOffState(lowPowerOffState),
    .deeperLowPowerOffState(deeperLowPowerOffState), .softOffState(softOffState), .faultClear(faultClear),
    .indicatorWhite(indicatorWhite), .faultLatched(faultLatched), .faultCode(faultCode));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_len(input int got, input int exp);
    compares++;
    if (got < exp - TOL || got > exp + TOL) begin
      error_cnt++;
      $display("Error t=%0t len=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts the cycles the indicator stays at lvl, bounded
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (indicatorWhite === lvl && n < 6 * U) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 6 * U) begin
      error_cnt++;
      $display("Error t=%0t stuck=%h exp=%h", $time, lvl, ~lvl);
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  // State word is {enable, on, low-power off, deeper off, soft-off}
  task automatic setup(input logic [4:0] st, input logic [5:0] mode);
    @(posedge sys_clk);
    {railEnableRequest, powerOnState, lowPowerOffState, deeperLowPowerOffState, softOffState} <= st;
    railMode <= mode;
    repeat (40) @(posedge sys_clk);
    faultClear <= 1'b1;
    @(posedge sys_clk);
    faultClear <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic edge_case(input logic [4:0] st, input int rail, input logic [1:0] rmode,
    input pfbr_code_type code);
    setup(st, 6'h00);
    @(negedge sys_clk);
    chk({7'h0, faultLatched}, 8'h00);
    @(posedge sys_clk);
    railMode[2*rail+:2] <= rmode;
    repeat (12) @(negedge sys_clk);
    chk({7'h0, faultLatched}, 8'h01);
    chk(faultCode, code);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic timeout_case(input int rail, input pfbr_code_type code);
    setup(5'h00, 6'h00);
    @(posedge sys_clk);
    railMode[2*rail+:2] <= 2'h1;
    railEnableRequest <= 1'b1;
    repeat (1000 * MS - 10) @(negedge sys_clk);
    chk({7'h0, faultLatched}, 8'h00);
    repeat (4 * MS + 20) @(negedge sys_clk);
    chk({7'h0, faultLatched}, 8'h01);
    chk(faultCode, code);
  endtask

  task automatic blink_case();
    int n;
    pfbr_code_type code;
    code = 8'h21;
    edge_case(5'h18, 0, 2'h1, code);
    span(1'b0, n);
    chk_len(n, 4 * U);
    chk({7'h0, indicatorWhite}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      span(1'b1, n);
      if (code[i]) begin
        chk_len(n, 2 * U);
      end else begin
        chk_len(n, U);
      end
      span(1'b0, n);
      if (i == 7) begin
        chk_len(n, 4 * U);
      end else begin
        chk_len(n, U);
      end
    end
    chk({7'h0, indicatorWhite}, 8'h01);
  endtask

  // Mid-run reset in soft-off with the P rail held up: outputs clear and the
  // rail that was already up is not reported as a rise
  task automatic reset_case();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({6'h0, faultLatched, indicatorWhite}, 8'h00);
    chk(faultCode, 8'h00);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (12) @(negedge sys_clk);
    chk({7'h0, faultLatched}, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    blink_case();
    timeout_case(0, 8'h20);
    timeout_case(1, 8'h30);
    timeout_case(2, 8'h40);
    edge_case(5'h18, 1, 2'h1, 8'h31);
    edge_case(5'h18, 2, 2'h1, 8'h41);
    edge_case(5'h14, 0, 2'h1, 8'h22);
    edge_case(5'h12, 0, 2'h1, 8'h22);
    edge_case(5'h14, 1, 2'h1, 8'h32);
    edge_case(5'h01, 0, 2'h2, 8'h23);
    edge_case(5'h01, 1, 2'h2, 8'h33);
    edge_case(5'h01, 2, 2'h2, 8'h43);
    reset_case();
    end_of_test();
  end
endmodule
